// >>> vdmc_pkg.sv
package vdmc_pkg;
    // ----------------
    // register map (byte addresses)
    // ----------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_FMT    = 8'h04;
    localparam logic [7:0] ADDR_HSYNC  = 8'h08;
    localparam logic [7:0] ADDR_VSYNC  = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MK = 8'h18;
    localparam logic [7:0] ADDR_SLAVE  = 8'h1C;
    // ----------------
    // slave addresses
    // ----------------
    localparam logic [6:0] CTRL_ADDR_LO = 7'h40 >> 1;
    localparam logic [7:0] CTRL_WR_LO   = 8'h40;
    localparam logic [7:0] CTRL_WR_HI   = 8'h42;
    localparam logic [7:0] READ_LO      = 8'h21;
    localparam logic [7:0] READ_HI      = 8'h23;
    // ----------------
    // ctrl fields
    // ----------------
    localparam int CTRL_CP        = 0;
    localparam int CTRL_DE        = 1;
    localparam int CTRL_CSYNC     = 2;
    localparam int CTRL_FIVE_WIRE = 3;
    localparam int CTRL_FREE_RUN  = 4;
    localparam int CTRL_FB_EN     = 5;
    localparam int CTRL_HPOL      = 6;
    localparam int CTRL_VPOL      = 7;
    localparam int CTRL_FPOL      = 8;
    localparam int CTRL_STD_LSB   = 12;  // 4-bit input standard
    localparam int CTRL_PHASE_LSB = 16;  // 5-bit sampling phase
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    // fmt: [1:0] sd format, [3:2] cp format, [5:4] sd timing carriage
    localparam logic [31:0] FMT_RESET   = 32'h0000_0030;
    // sync position [11:0], width [23:12]
    localparam logic [31:0] HSYNC_RESET = 32'h0004_0010;
    localparam logic [31:0] VSYNC_RESET = 32'h0000_3001;
    // ----------------
    // input standards and formats
    // ----------------
    localparam logic [3:0] STD_CVBS   = 4'h0;
    localparam logic [3:0] STD_SVIDEO = 4'h1;
    localparam logic [3:0] STD_525I   = 4'h2;
    localparam logic [3:0] STD_625I   = 4'h3;
    localparam logic [3:0] STD_525P   = 4'h4;
    localparam logic [3:0] STD_625P   = 4'h5;
    localparam logic [3:0] STD_GFX    = 4'hC;
    localparam logic [1:0] CP_SDR8    = 2'h0;
    localparam logic [1:0] CP_SDR16   = 2'h1;
    localparam logic [1:0] CP_DDR8    = 2'h2;
    localparam logic [1:0] CP_DDR12   = 2'h3;
    localparam logic [1:0] OSR_1X     = 2'h0;
    localparam logic [1:0] OSR_2X     = 2'h1;
    localparam logic [1:0] OSR_4X     = 2'h2;
    // ----------------
    // timing
    // ----------------
    localparam int CLK_HZ        = 20_000_000;
    localparam int RESET_MS      = 5;
    localparam int RESET_CYCLES  = CLK_HZ / 1000 * RESET_MS;
    localparam int LLC_MIN_KHZ   = 12825;
    localparam int LLC_MAX_KHZ   = 110000;
    localparam int SCL_MAX_KHZ   = 400;
    localparam int LINE_CYCLES   = 1280;
    localparam int FRAME_LINES   = 525;
    localparam int ACTIVE_FIRST  = 16'h0100;
    localparam int ACTIVE_LINE   = 20;
    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_DECERR = 2'b11;
endpackage

// >>> vdmc_sync_gen.sv
`timescale 1ns/1ns
// programmable sync pulse: asserts from pos for wid counts
module vdmc_sync_gen #(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // timing
    input  wire logic [W-1:0] count,
    input  wire logic [W-1:0] pos,
    input  wire logic [W-1:0] wid,
    input  wire logic         pol,
    // result
    output logic              sync_q
);
    logic [W:0] rel;
    logic       active;

    // pulse window, polarity applied last
    assign rel    = {1'b0, count} - {1'b0, pos};
    assign active = (count >= pos) && (rel[W-1:0] < wid);

    // registered output
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync_q <= 1'b0;
        end else begin
            sync_q <= active ^ pol;
        end
    end
endmodule

// >>> vdmc_top.sv
`timescale 1ns/1ns
module vdmc_top #(
    parameter int H_TOTAL = vdmc_pkg::LINE_CYCLES,
    parameter int V_TOTAL = vdmc_pkg::FRAME_LINES,
    parameter int H_ACTIVE = vdmc_pkg::ACTIVE_FIRST,
    parameter int V_ACTIVE = vdmc_pkg::ACTIVE_LINE
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // pins from outside
    input  wire logic        address_low_select_pin,
    input  wire logic        fast_blank_select,
    input  wire logic        horizontal_or_composite_sync_input,
    input  wire logic        vertical_sync_input,
    input  wire logic        line_locked_pixel_clock,
    input  wire logic        video_present,
    input  wire logic        sd_status_event,
    input  wire logic        cp_status_event,
    // sync outputs
    output logic             horizontal_or_composite_sync_output,
    output logic             vertical_sync_output,
    output logic             field_or_data_enable_output,
    // overlay and sampling
    output logic             overlay_rgb_select,
    output logic [1:0]       oversample_ratio,
    output logic [4:0]       sampling_phase,
    output logic             cp_selected,
    // interrupt
    output logic             irq
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] meta_q;
    logic [NSYNC-1:0] pin_q;
    logic [NSYNC-1:0] pin_prev_q;

    assign pin_raw = {cp_status_event, sd_status_event, video_present,
                      line_locked_pixel_clock, vertical_sync_input,
                      horizontal_or_composite_sync_input, fast_blank_select,
                      address_low_select_pin};

    // two flops per pin, then a delayed copy for edge detection
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_q     <= '0;
            pin_q      <= '0;
            pin_prev_q <= '0;
        end else begin
            meta_q     <= pin_raw;
            pin_q      <= meta_q;
            pin_prev_q <= pin_q;
        end
    end

    logic address_low_select_pin_s, fb_s, hcs_s, vs_s, llc_s, vp_s;
    logic llc_rise, hcs_rise, vs_rise, sd_evt, cp_evt;
    assign address_low_select_pin_s   = pin_q[0];
    assign fb_s     = pin_q[1];
    assign hcs_s    = pin_q[2];
    assign vs_s     = pin_q[3];
    assign llc_s    = pin_q[4];
    assign vp_s     = pin_q[5];
    assign llc_rise = llc_s & ~pin_prev_q[4];
    assign hcs_rise = hcs_s & ~pin_prev_q[2];
    assign vs_rise  = vs_s & ~pin_prev_q[3];
    assign sd_evt   = pin_q[6] ^ pin_prev_q[6];
    assign cp_evt   = pin_q[7] ^ pin_prev_q[7];

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_q, fmt_q, hsync_q, vsync_q, irq_st_q, irq_mk_q;
    logic        wr_en;
    logic [7:0]  wr_addr_q;
    logic [31:0] wr_data_q;
    logic [3:0]  wr_strb_q;
    logic        aw_have_q, w_have_q;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // defaults held until the host writes
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_q  <= vdmc_pkg::CTRL_RESET;
            fmt_q   <= vdmc_pkg::FMT_RESET;
            hsync_q <= vdmc_pkg::HSYNC_RESET;
            vsync_q <= vdmc_pkg::VSYNC_RESET;
            irq_mk_q <= '0;
        end else if (wr_en) begin
            case (wr_addr_q)
                vdmc_pkg::ADDR_CTRL:   ctrl_q   <= merge(ctrl_q, wr_data_q, wr_strb_q);
                vdmc_pkg::ADDR_FMT:    fmt_q    <= merge(fmt_q, wr_data_q, wr_strb_q);
                vdmc_pkg::ADDR_HSYNC:  hsync_q  <= merge(hsync_q, wr_data_q, wr_strb_q);
                vdmc_pkg::ADDR_VSYNC:  vsync_q  <= merge(vsync_q, wr_data_q, wr_strb_q);
                vdmc_pkg::ADDR_IRQ_MK: irq_mk_q <= merge(irq_mk_q, wr_data_q, wr_strb_q);
                default: ;
            endcase
        end
    end

    logic       cp_mode, de_mode, csync_mode, five_wire, free_run, fb_en;
    logic [3:0] std;
    assign cp_mode    = ctrl_q[vdmc_pkg::CTRL_CP];
    assign de_mode    = ctrl_q[vdmc_pkg::CTRL_DE];
    assign csync_mode = ctrl_q[vdmc_pkg::CTRL_CSYNC];
    assign five_wire  = ctrl_q[vdmc_pkg::CTRL_FIVE_WIRE];
    assign free_run   = ctrl_q[vdmc_pkg::CTRL_FREE_RUN];
    assign fb_en      = ctrl_q[vdmc_pkg::CTRL_FB_EN];
    assign std        = ctrl_q[vdmc_pkg::CTRL_STD_LSB +: 4];

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    assign wr_en = aw_have_q && w_have_q && !s_axi_bvalid;

    // accept address and data in either order, answer after both
    always_ff @(posedge clk) begin
        if (!resetn) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= vdmc_pkg::AXI_OKAY;
            wr_addr_q     <= '0;
            wr_data_q     <= '0;
            wr_strb_q     <= '0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                wr_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q  <= 1'b1;
                wr_data_q <= s_axi_wdata;
                wr_strb_q <= s_axi_wstrb;
            end
            if (wr_en) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_addr_q <= vdmc_pkg::ADDR_SLAVE &&
                                 wr_addr_q[1:0] == 2'b00) ?
                                vdmc_pkg::AXI_OKAY : vdmc_pkg::AXI_DECERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status, write one to clear, set wins
    // ------------------------------------------------------------
    logic [1:0] evt;
    logic [1:0] clr;
    assign evt = {cp_evt, sd_evt};
    assign clr = (wr_en && wr_addr_q == vdmc_pkg::ADDR_IRQ_ST && wr_strb_q[0]) ?
                 wr_data_q[1:0] : 2'b00;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_st_q <= '0;
            irq      <= 1'b0;
        end else begin
            irq_st_q[1:0] <= (irq_st_q[1:0] & ~clr) | evt;
            irq           <= |(irq_st_q[1:0] & irq_mk_q[1:0]);
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic [7:0]  wr_slave, rd_slave;

    // bus addresses follow the select pin
    assign wr_slave = address_low_select_pin_s ? vdmc_pkg::CTRL_WR_HI : vdmc_pkg::CTRL_WR_LO;
    assign rd_slave = address_low_select_pin_s ? vdmc_pkg::READ_HI : vdmc_pkg::READ_LO;
    assign status_word = {24'h0000_00, vp_s, fb_s, free_run, cp_mode,
                          oversample_ratio, llc_s, address_low_select_pin_s};

    always_comb begin
        case (s_axi_araddr)
            vdmc_pkg::ADDR_CTRL:   rd_mux = ctrl_q;
            vdmc_pkg::ADDR_FMT:    rd_mux = fmt_q;
            vdmc_pkg::ADDR_HSYNC:  rd_mux = hsync_q;
            vdmc_pkg::ADDR_VSYNC:  rd_mux = vsync_q;
            vdmc_pkg::ADDR_STATUS: rd_mux = status_word;
            vdmc_pkg::ADDR_IRQ_ST: rd_mux = irq_st_q;
            vdmc_pkg::ADDR_IRQ_MK: rd_mux = irq_mk_q;
            vdmc_pkg::ADDR_SLAVE:  rd_mux = {16'h0000, rd_slave, wr_slave};
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= vdmc_pkg::AXI_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= (s_axi_araddr <= vdmc_pkg::ADDR_SLAVE &&
                                 s_axi_araddr[1:0] == 2'b00) ?
                                vdmc_pkg::AXI_OKAY : vdmc_pkg::AXI_DECERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // mode decode: oversampling, phase, processor select
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            oversample_ratio <= vdmc_pkg::OSR_4X;
            sampling_phase   <= '0;
            cp_selected      <= 1'b0;
        end else begin
            cp_selected    <= cp_mode;
            sampling_phase <= (std == vdmc_pkg::STD_GFX) ?
                              ctrl_q[vdmc_pkg::CTRL_PHASE_LSB +: 5] : 5'h00;
            case (std)
                vdmc_pkg::STD_CVBS, vdmc_pkg::STD_SVIDEO:
                    oversample_ratio <= vdmc_pkg::OSR_4X;
                vdmc_pkg::STD_525I, vdmc_pkg::STD_625I,
                vdmc_pkg::STD_525P, vdmc_pkg::STD_625P:
                    oversample_ratio <= vdmc_pkg::OSR_2X;
                default:
                    oversample_ratio <= vdmc_pkg::OSR_1X;
            endcase
        end
    end

    // ------------------------------------------------------------
    // timing counters, stepped on pixel clock rising edges
    // ------------------------------------------------------------
    logic [11:0] h_cnt_q, v_cnt_q;
    logic        field_q;
    logic        ext_hs, ext_vs, lock_ext;

    // component mode with video present and free_run clear takes sync from pins (vsync only if five_wire), otherwise free-run
    assign lock_ext = cp_mode && vp_s && !free_run;
    assign ext_hs   = lock_ext && (csync_mode ? hcs_rise : hcs_rise);
    assign ext_vs   = lock_ext && five_wire && vs_rise;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            h_cnt_q <= '0;
            v_cnt_q <= '0;
            field_q <= 1'b0;
        end else if (ext_hs) begin
            h_cnt_q <= '0;
            v_cnt_q <= ext_vs ? 12'h000 : v_cnt_q + 12'h001;
        end else if (ext_vs) begin
            v_cnt_q <= '0;
            field_q <= ~field_q;
        end else if (llc_rise) begin
            if (h_cnt_q == 12'(H_TOTAL - 1)) begin
                h_cnt_q <= '0;
                if (v_cnt_q == 12'(V_TOTAL - 1)) begin
                    v_cnt_q <= '0;
                    field_q <= ~field_q;
                end else begin
                    v_cnt_q <= v_cnt_q + 12'h001;
                end
            end else begin
                h_cnt_q <= h_cnt_q + 12'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // sync outputs
    // ------------------------------------------------------------
    logic hs_gen, vs_gen;

    vdmc_sync_gen #(.W(12)) u_hs (
        .clk    (clk),
        .resetn (resetn),
        .count  (h_cnt_q),
        .pos    (hsync_q[11:0]),
        .wid    (hsync_q[23:12]),
        .pol    (ctrl_q[vdmc_pkg::CTRL_HPOL]),
        .sync_q (hs_gen)
    );

    vdmc_sync_gen #(.W(12)) u_vs (
        .clk    (clk),
        .resetn (resetn),
        .count  (v_cnt_q),
        .pos    (vsync_q[11:0]),
        .wid    (vsync_q[23:12]),
        .pol    (ctrl_q[vdmc_pkg::CTRL_VPOL]),
        .sync_q (vs_gen)
    );

    logic active_video;
    assign active_video = (h_cnt_q >= 12'(H_ACTIVE)) &&
                          (v_cnt_q >= 12'(V_ACTIVE));

    // outputs registered; field pin may carry data enable in cp mode
    always_ff @(posedge clk) begin
        if (!resetn) begin
            horizontal_or_composite_sync_output <= 1'b0;
            vertical_sync_output                <= 1'b0;
            field_or_data_enable_output         <= 1'b0;
            overlay_rgb_select                  <= 1'b0;
        end else begin
            horizontal_or_composite_sync_output <= csync_mode && cp_mode ?
                                                   (hs_gen ^ vs_gen) : hs_gen;
            vertical_sync_output <= vs_gen;
            field_or_data_enable_output <= (cp_mode && de_mode) ?
                active_video : (field_q ^ ctrl_q[vdmc_pkg::CTRL_FPOL]);
            overlay_rgb_select <= fb_en && fb_s && active_video;
        end
    end

    // output format fields in fmt_q are only stored and read back; no logic uses them
    logic unused_fmt;
    assign unused_fmt = ^fmt_q;
endmodule

// >>> vdmc_top_properties.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module vdmc_top_checker (
    // clock and reset
    input logic        clk,
    input logic        resetn,
    // bus
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    // pins
    input logic        fast_blank_select,
    input logic        overlay_rgb_select,
    input logic [1:0]  oversample_ratio,
    input logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // settings after reset
    a_reset_defaults: assert property (disable iff (1'b0) !resetn |=>
        oversample_ratio == vdmc_pkg::OSR_4X && !irq && !overlay_rgb_select)
        else $error("outputs not at reset values");
    a_osr_legal: assert property (oversample_ratio != 2'h3)
        else $error("oversample ratio code unused");
    a_overlay_cause: assert property ($rose(overlay_rgb_select) |->
        $past(fast_blank_select, 2) || $past(fast_blank_select, 3) || $past(fast_blank_select, 4))
        else $error("overlay without fast blank");
    // bus answers
    a_rvalid_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_bresp_legal: assert property (s_axi_bvalid |->
        s_axi_bresp == vdmc_pkg::AXI_OKAY || s_axi_bresp == vdmc_pkg::AXI_DECERR)
        else $error("bad write response");
    a_decerr_zero: assert property (s_axi_rvalid && s_axi_rresp == vdmc_pkg::AXI_DECERR |->
        s_axi_rdata == 32'h0000_0000)
        else $error("refused read carries data");
    // main scenarios
    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
    c_read_refused: cover property (s_axi_rvalid && s_axi_rresp == vdmc_pkg::AXI_DECERR);
    c_irq_seen: cover property ($rose(irq));
endmodule

bind vdmc_top vdmc_top_checker vdmc_top_checker_inst (.clk, .resetn, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .fast_blank_select, .overlay_rgb_select, .oversample_ratio,
    .irq);

// >>> vdmc_video_source.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// upstream video source: free pixel clock and syncs
// ------------------------------------------------------------
module vdmc_video_source (
    // pixel side
    output logic line_locked_pixel_clock,
    output logic horizontal_or_composite_sync_input,
    output logic vertical_sync_input,
    output logic video_present
);
    logic [6:0] pix_q;
    // pixel clock, 400 ns, off phase from clk
    initial begin
        line_locked_pixel_clock = 1'b0;
        pix_q = 7'h00;
        #37;
        forever #200 line_locked_pixel_clock = ~line_locked_pixel_clock;
    end
    // pixel counter
    always @(posedge line_locked_pixel_clock) pix_q <= pix_q + 7'h01;
    // sync pulses per line and frame
    assign horizontal_or_composite_sync_input = (pix_q[3:0] == 4'h0);
    assign vertical_sync_input = (pix_q[6:4] == 3'h0);
    assign video_present = 1'b1;
endmodule

// >>> vdmc_top_test.sv
`timescale 1ns/1ns
module vdmc_top_test;
    // ----------------
    // signals
    // ----------------
    logic        clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, address_low_select_pin, fast_blank_select, irq;
    logic        horizontal_or_composite_sync_input, vertical_sync_input, video_present;
    logic        line_locked_pixel_clock, sd_status_event, cp_status_event, cp_selected;
    logic        horizontal_or_composite_sync_output, vertical_sync_output;
    logic        field_or_data_enable_output, overlay_rgb_select;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, oversample_ratio, rd_resp;
    logic [4:0]  sampling_phase;
    int          failures, checked, i, n;

    vdmc_top #(.H_TOTAL(16), .V_TOTAL(8), .H_ACTIVE(8), .V_ACTIVE(2)) vdmc_top_inst (.*);
    vdmc_video_source vdmc_video_source_inst (.line_locked_pixel_clock,
        .horizontal_or_composite_sync_input, .vertical_sync_input, .video_present);

    // ----------------
    // tasks
    // ----------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------
    // clock and watchdog
    // ----------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        wrap_up();
    end

    // ----------------
    // tests
    // ----------------
    initial begin
        logic [7:0]  ra [4] = '{vdmc_pkg::ADDR_CTRL, vdmc_pkg::ADDR_FMT, vdmc_pkg::ADDR_HSYNC,
                                vdmc_pkg::ADDR_VSYNC};
        logic [31:0] re [4] = '{vdmc_pkg::CTRL_RESET, vdmc_pkg::FMT_RESET,
                                vdmc_pkg::HSYNC_RESET, vdmc_pkg::VSYNC_RESET};
        logic [3:0]  st [7] = '{vdmc_pkg::STD_CVBS, vdmc_pkg::STD_SVIDEO, vdmc_pkg::STD_525I,
            vdmc_pkg::STD_625I, vdmc_pkg::STD_525P, vdmc_pkg::STD_625P, vdmc_pkg::STD_GFX};
        logic [1:0]  os [7] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0};
        {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, address_low_select_pin, fast_blank_select} = '0;
        {sd_status_event, cp_status_event, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        failures = 0;
        checked = 0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        // register defaults after reset
        chk("oversample at reset", 32'(vdmc_pkg::OSR_4X), 32'(oversample_ratio));
        for (i = 0; i < 4; i++) begin
            rd(ra[i]);
            chk("register reset", re[i], rd_data);
        end
        // slave addresses follow the select pin, writes ignored
        for (i = 0; i < 2; i++) begin
            address_low_select_pin <= i[0];
            repeat (4) @(posedge clk);
            wr(vdmc_pkg::ADDR_SLAVE, 32'h0000_0000);
            rd(vdmc_pkg::ADDR_SLAVE);
            chk("slave addrs", i ? 32'h0000_2342 : 32'h0000_2140, {16'h0000, rd_data[15:0]});
        end
        // unmapped and misaligned reads refused
        for (i = 0; i < 2; i++) begin
            rd(i ? 8'h02 : 8'h20);
            chk("refused resp", 32'(vdmc_pkg::AXI_DECERR), 32'(rd_resp));
        end
        // oversampling and processor per standard, phase for the graphics standard only
        for (i = 0; i < 7; i++) begin
            wr(vdmc_pkg::ADDR_CTRL, (32'(st[i]) << 12) | 32'(i >= 2) | (i == 6 ? 32'h001F_0000 : 0));
            rd(vdmc_pkg::ADDR_CTRL);
            chk("oversample", 32'(os[i]), 32'(oversample_ratio));
            chk("processor", 32'(i >= 2), 32'(cp_selected));
            if (i == 6) chk("phase", 32'h0000_001F, 32'(sampling_phase));
        end
        // interrupt: raise masked, unmask, clear, second source
        wr(vdmc_pkg::ADDR_IRQ_MK, 32'h0000_0000);
        sd_status_event <= 1'b1;
        repeat (6) @(posedge clk);
        rd(vdmc_pkg::ADDR_IRQ_ST);
        chk("irq status sd", 32'h0000_0001, rd_data);
        chk("irq masked", 32'h0, 32'(irq));
        wr(vdmc_pkg::ADDR_IRQ_MK, 32'h0000_0003);
        rd(vdmc_pkg::ADDR_IRQ_MK);
        chk("irq unmasked", 32'h1, 32'(irq));
        wr(vdmc_pkg::ADDR_IRQ_ST, 32'h0000_0001);
        rd(vdmc_pkg::ADDR_IRQ_ST);
        chk("irq cleared", 32'h0, rd_data | 32'(irq));
        cp_status_event <= 1'b1;
        repeat (6) @(posedge clk);
        rd(vdmc_pkg::ADDR_IRQ_ST);
        chk("irq status cp", 32'h0000_0002, rd_data);
        chk("irq cp", 32'h1, 32'(irq));
        // fast blank overlay during active video
        wr(vdmc_pkg::ADDR_CTRL, 32'h0000_0020);
        fast_blank_select <= 1'b1;
        n = 0;
        while (overlay_rgb_select !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        chk("overlay on", 32'h1, 32'(overlay_rgb_select));
        fast_blank_select <= 1'b0;
        repeat (6) @(posedge clk);
        chk("overlay off", 32'h0, 32'(overlay_rgb_select));
        wrap_up();
    end
endmodule
